/* File: timer8_pkg.sv */
// Constants, register map and field types of the 8-bit timer control and interrupt block.
//
// Contract
// (R01) A force-compare write applies that channel's output-mode action immediately.
// (R02) Force-compare bits act only in non-PWM waveform modes.
// (R03) Software writes force bits as zero while in a PWM mode.
// (R04) A forced compare sets no flag and never clears the counter.
// (R05) Force-compare bits 7 and 6 are strobes that read as zero.
// (R06) Control B bits 5:4 and mask/flag bits 7:3 read as zero.
// (R07) Clock select 0 stops, 1 undivided, 2..5 divide by 8, 64, 256, 1024.
// (R08) Code 110 counts falling count-pin edges, 111 counts rising edges.
// (R09) The count pin clocks the counter even when driven as an output.
// (R10) The counter is readable and writable by software at any time.
// (R11) A counter write suppresses both compare matches on the next timer tick.
// (R12) Each compare register is compared continuously; equality is a compare match.
// (R13) An interrupt is requested only while mask, global enable and flag are set.
// (R14) Flag 2 marks compare B, flag 1 compare A, flag 0 overflow.
// (R15) Executing an interrupt vector clears its flag automatically.
// (R16) Writing one to a flag clears it; writing zero leaves it.
// (R17) The overflow flag moment depends on the waveform mode; BOTTOM is 0x00.
// (R18) Overflow at MAX in normal, CTC, fixed fast PWM; BOTTOM phase-correct; TOP else.
// (R19) Non-PWM output modes: 00 off, 01 toggle, 10 clear, 11 set on match.
// (R20) Eight waveform modes: 0 normal, 2 CTC, 1/5 phase-correct, 3/7 fast, 4/6 reserved.
// (R21) With the clock stopped, counter, outputs and flags hold their values.
package timer8_pkg;

    // Bus geometry; each register index maps to byte address index * 4.
    localparam int         ADDR_W      = 8;
    localparam int         DATA_W      = 32;
    localparam int         IDX_W       = 6;
    localparam logic [5:0] IDX_CTRL_A  = 6'h24;
    localparam logic [5:0] IDX_CTRL_B  = 6'h25;
    localparam logic [5:0] IDX_COUNT   = 6'h26;
    localparam logic [5:0] IDX_CMP_A   = 6'h27;
    localparam logic [5:0] IDX_CMP_B   = 6'h28;
    localparam logic [5:0] IDX_MASK    = 6'h2E;
    localparam logic [5:0] IDX_FLAGS   = 6'h15;
    localparam logic [5:0] IDX_GIE     = 6'h3F;

    // Field positions and widths.
    localparam int FORCE_A_BIT  = 7;
    localparam int FORCE_B_BIT  = 6;
    localparam int WAVE_HI_BIT  = 3;
    localparam int GIE_BIT      = 0;
    localparam int FLAG_CMP_B   = 2;
    localparam int FLAG_CMP_A   = 1;
    localparam int FLAG_OVF     = 0;
    localparam int IRQ_N        = 3;
    localparam int PRE_W        = 10;

    // Reset and boundary values.
    localparam logic [7:0] BYTE_ZERO    = 8'h00;
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_ONE    = 8'h01;

    // Clock select codes and prescaler tap masks.
    localparam logic [2:0] CS_STOP     = 3'h0;
    localparam logic [2:0] CS_DIV1     = 3'h1;
    localparam logic [2:0] CS_DIV8     = 3'h2;
    localparam logic [2:0] CS_DIV64    = 3'h3;
    localparam logic [2:0] CS_DIV256   = 3'h4;
    localparam logic [2:0] CS_DIV1024  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] TAP_8       = 10'h007;
    localparam logic [9:0] TAP_64      = 10'h03F;
    localparam logic [9:0] TAP_256     = 10'h0FF;
    localparam logic [9:0] TAP_1024    = 10'h3FF;

    // Output modes.
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // Waveform modes.
    localparam logic [2:0] WM_NORMAL    = 3'h0;
    localparam logic [2:0] WM_PC_FIXED  = 3'h1;
    localparam logic [2:0] WM_CTC       = 3'h2;
    localparam logic [2:0] WM_FAST_FIX  = 3'h3;
    localparam logic [2:0] WM_PC_TOPA   = 3'h5;
    localparam logic [2:0] WM_FAST_TOPA = 3'h7;

    // Control register A layout.
    typedef struct packed {
        logic [1:0] outputModeA;
        logic [1:0] outputModeB;
        logic [1:0] reserved;
        logic [1:0] waveModeLow;
    } ctrl_a_t;

    // Counting direction of the phase-correct sequence.
    typedef enum {COUNT_UP, COUNT_DOWN} count_dir_t;

endpackage

/* File: timer8_ctrl_irq.sv */
// Control, counter, compare and interrupt-flag logic of an 8-bit timer behind an APB slave.
`timescale 1ns/1ps
module timer8_ctrl_irq
    import timer8_pkg::*;
(
    // Clock and reset.
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    // APB slave.
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [DATA_W-1:0]   pwdata,
    output logic      [DATA_W-1:0]   prdata,
    output logic                     pready,
    output logic                     pslverr,
    // External count pin, asynchronous.
    input  wire logic                extCountPin,
    // Vector-executed pulses from the CPU, one per interrupt.
    input  wire logic [IRQ_N-1:0]    vectorAck,
    // Interrupt requests and waveform outputs.
    output logic      [IRQ_N-1:0]    irqRequest,
    output logic                     waveOutA,
    output logic                     waveEnableA,
    output logic                     waveOutB,
    output logic                     waveEnableB
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release synchroniser; assert is immediate, release takes two edges.
    logic rstMeta;
    logic rstSync;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.
    ctrl_a_t          ctrlA;
    logic             waveModeHigh;
    logic [2:0]       clockSelect;
    logic [7:0]       count;
    logic [7:0]       cmpA;
    logic [7:0]       cmpB;
    logic [IRQ_N-1:0] irqMask;
    logic [IRQ_N-1:0] flags;
    logic             globalEnable;
    logic             blockNext;
    count_dir_t       dir;
    logic [PRE_W-1:0] prescale;

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states, so pready is always high.
    wire [IDX_W-1:0] regIdx     = paddr[ADDR_W-1:2];
    wire             aligned    = (paddr[1:0] == 2'h0);
    wire             hitCtrlA   = aligned && (regIdx == IDX_CTRL_A);
    wire             hitCtrlB   = aligned && (regIdx == IDX_CTRL_B);
    wire             hitCount   = aligned && (regIdx == IDX_COUNT);
    wire             hitCmpA    = aligned && (regIdx == IDX_CMP_A);
    wire             hitCmpB    = aligned && (regIdx == IDX_CMP_B);
    wire             hitMask    = aligned && (regIdx == IDX_MASK);
    wire             hitFlags   = aligned && (regIdx == IDX_FLAGS);
    wire             hitGie     = aligned && (regIdx == IDX_GIE);
    wire             mapped     = hitCtrlA | hitCtrlB | hitCount | hitCmpA | hitCmpB
                                | hitMask | hitFlags | hitGie;
    wire             access     = psel && penable;
    wire             writeOk    = access && pwrite && mapped;
    wire             ctrlAWrite = writeOk && hitCtrlA;
    wire             ctrlBWrite = writeOk && hitCtrlB;
    wire             countWrite = writeOk && hitCount;
    wire             flagWrite  = writeOk && hitFlags;

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // Read view; strobes and reserved bits read as zero.
    logic [7:0] readByte;
    always_comb
    begin
        readByte = BYTE_ZERO;
        if (hitCtrlA)
            readByte = {ctrlA.outputModeA, ctrlA.outputModeB, 2'h0, ctrlA.waveModeLow};
        else if (hitCtrlB)
            readByte = {4'h0, waveModeHigh, clockSelect};          // R05 R06
        else if (hitCount)
            readByte = count;                                      // R10
        else if (hitCmpA)
            readByte = cmpA;
        else if (hitCmpB)
            readByte = cmpB;
        else if (hitMask)
            readByte = {5'h00, irqMask};                           // R06
        else if (hitFlags)
            readByte = {5'h00, flags};                             // R06
        else if (hitGie)
            readByte = {7'h00, globalEnable};
    end

    // Read data is captured in the setup cycle and held through the access.
    always_ff @(posedge core_clk or negedge rstSync)
    begin
        if (!rstSync)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
            prdata <= {24'h00_0000, readByte};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode.
    wire [2:0] waveMode = {waveModeHigh, ctrlA.waveModeLow};
    wire       isPwm    = ctrlA.waveModeLow[0];                    // R20
    wire       isPc     = (waveMode == WM_PC_FIXED) || (waveMode == WM_PC_TOPA);
    wire       isFast   = (waveMode == WM_FAST_FIX) || (waveMode == WM_FAST_TOPA);
    wire       isCtc    = (waveMode == WM_CTC);
    wire       topIsA   = isCtc || (waveMode == WM_PC_TOPA) || (waveMode == WM_FAST_TOPA);
    wire [7:0] topVal   = topIsA ? cmpA : COUNT_MAX;

    ////////////////////////////////////////////////////////////////////////////////
    // Count pin: three flops, the level moves only when stages two and three agree.
    logic extS1;
    logic extS2;
    logic extS3;
    logic extLevel;
    logic extLevelOld;

    always_ff @(posedge core_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            extS1       <= 1'b0;
            extS2       <= 1'b0;
            extS3       <= 1'b0;
            extLevel    <= 1'b0;
            extLevelOld <= 1'b0;
        end
        else
        begin
            extS1       <= extCountPin;                            // R09
            extS2       <= extS1;
            extS3       <= extS2;
            extLevel    <= (extS2 == extS3) ? extS3 : extLevel;
            extLevelOld <= extLevel;
        end
    end

    wire extRise = extLevel && !extLevelOld;
    wire extFall = !extLevel && extLevelOld;

    // Free-running prescaler; sharing it between taps keeps the divider tiny, at the
    // cost of a first tick that may come early after a select change.
    always_ff @(posedge core_clk or negedge rstSync)
    begin
        if (!rstSync)
            prescale <= '0;
        else
            prescale <= prescale + 1'b1;
    end

    function automatic logic tapHit(input logic [PRE_W-1:0] pre, input logic [PRE_W-1:0] mask);
        tapHit = ((pre & mask) == mask);
    endfunction

    // Timer tick selection; a stopped select yields no tick at all.
    logic tick;
    always_comb
    begin
        case (clockSelect)
            CS_STOP:     tick = 1'b0;                              // R21
            CS_DIV1:     tick = 1'b1;                              // R07
            CS_DIV8:     tick = tapHit(prescale, TAP_8);           // R07
            CS_DIV64:    tick = tapHit(prescale, TAP_64);
            CS_DIV256:   tick = tapHit(prescale, TAP_256);
            CS_DIV1024:  tick = tapHit(prescale, TAP_1024);
            CS_EXT_FALL: tick = extFall;                           // R08
            CS_EXT_RISE: tick = extRise;                           // R08
            default:     tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare matches, suppressed on the tick after a counter write.
    wire matchA   = tick && !blockNext && (count == cmpA);        // R11 R12
    wire matchB   = tick && !blockNext && (count == cmpB);        // R11 R12
    wire atTop    = (count == topVal);
    wire wrapTick = tick && atTop && !isPc;

    // Overflow moment per waveform mode.
    logic ovfEvent;
    always_comb
    begin
        if (isPc)
            ovfEvent = tick && (dir == COUNT_DOWN) && (count == COUNT_BOTTOM);   // R18
        else if (waveMode == WM_FAST_TOPA)
            ovfEvent = tick && atTop;                              // R18
        else
            ovfEvent = tick && (count == COUNT_MAX);               // R17 R18
    end

    // Counter and direction; a software write wins over a tick.
    always_ff @(posedge core_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            count <= BYTE_ZERO;
            dir   <= COUNT_UP;
        end
        else if (countWrite)
            count <= pwdata[7:0];                                  // R10
        else if (tick)
        begin
            if (isPc && dir == COUNT_UP && atTop)
            begin
                dir   <= COUNT_DOWN;
                count <= count - COUNT_ONE;
            end
            else if (isPc && dir == COUNT_DOWN && count == COUNT_BOTTOM)
            begin
                dir   <= COUNT_UP;
                count <= count + COUNT_ONE;
            end
            else if (isPc && dir == COUNT_DOWN)
                count <= count - COUNT_ONE;
            else if ((isCtc || isFast) && atTop)
                count <= COUNT_BOTTOM;                             // R04
            else
                count <= count + COUNT_ONE;
        end
    end

    // Block flag: set by a counter write, spent by the next tick.
    always_ff @(posedge core_clk or negedge rstSync)
    begin
        if (!rstSync)
            blockNext <= 1'b0;
        else if (countWrite)
            blockNext <= 1'b1;                                     // R11
        else if (tick)
            blockNext <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers.
    always_ff @(posedge core_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            ctrlA        <= '0;
            waveModeHigh <= 1'b0;
            clockSelect  <= CS_STOP;
            cmpA         <= BYTE_ZERO;
            cmpB         <= BYTE_ZERO;
            irqMask      <= '0;
            globalEnable <= 1'b0;
        end
        else
        begin
            if (ctrlAWrite)
                ctrlA <= ctrl_a_t'(pwdata[7:0]);
            if (ctrlBWrite)
            begin
                waveModeHigh <= pwdata[WAVE_HI_BIT];
                clockSelect  <= pwdata[2:0];                       // R07
            end
            if (writeOk && hitCmpA)
                cmpA <= pwdata[7:0];
            if (writeOk && hitCmpB)
                cmpB <= pwdata[7:0];
            if (writeOk && hitMask)
                irqMask <= pwdata[IRQ_N-1:0];
            if (writeOk && hitGie)
                globalEnable <= pwdata[GIE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags: sets win over clears; forced compares never reach them.
    wire [IRQ_N-1:0] flagSet   = {matchB, matchA, ovfEvent};                 // R14 R04
    wire [IRQ_N-1:0] flagClear = (flagWrite ? pwdata[IRQ_N-1:0] : '0)      // R16
                               | vectorAck;                                  // R15
    wire [IRQ_N-1:0] next_flags = (flags & ~flagClear) | flagSet;

    always_ff @(posedge core_clk or negedge rstSync)
    begin
        if (!rstSync)
            flags <= '0;
        else
            flags <= next_flags;
    end

    assign irqRequest = flags & irqMask & {IRQ_N{globalEnable}};             // R13

    ////////////////////////////////////////////////////////////////////////////////
    // Waveform outputs.
    wire forceA = ctrlBWrite && pwdata[FORCE_A_BIT] && !isPwm;   // R01 R02
    wire forceB = ctrlBWrite && pwdata[FORCE_B_BIT] && !isPwm;   // R01 R02

    // Next output level for one channel.
    function automatic logic waveNext(
        input logic       cur,
        input logic [1:0] com,
        input logic       hit,
        input logic       bottom,
        input logic       pwm,
        input logic       fast,
        input logic       down,
        input logic       toggleOk
    );
        waveNext = cur;
        if (!pwm)
        begin
            if (hit)
            begin
                case (com)
                    COM_TOGGLE: waveNext = !cur;                   // R19
                    COM_CLEAR:  waveNext = 1'b0;
                    COM_SET:    waveNext = 1'b1;
                    default:    waveNext = cur;
                endcase
            end
        end
        else if (com == COM_TOGGLE)
            waveNext = (hit && toggleOk) ? !cur : cur;
        else if (com[1] && fast)
        begin
            if (bottom)
                waveNext = !com[0];
            else if (hit)
                waveNext = com[0];
        end
        else if (com[1] && hit)
            waveNext = com[0] ^ down;
    endfunction

    always_ff @(posedge core_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            waveOutA <= 1'b0;
            waveOutB <= 1'b0;
        end
        else
        begin
            waveOutA <= waveNext(waveOutA, ctrlA.outputModeA, matchA || forceA, wrapTick,
                                 isPwm, isFast, dir == COUNT_DOWN, waveModeHigh);   // R01
            waveOutB <= waveNext(waveOutB, ctrlA.outputModeB, matchB || forceB, wrapTick,
                                 isPwm, isFast, dir == COUNT_DOWN, 1'b0);
        end
    end

    // A channel drives its pin only while its output mode is not off.
    assign waveEnableA = (ctrlA.outputModeA != COM_OFF);           // R19
    assign waveEnableB = (ctrlA.outputModeB != COM_OFF);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstSync);

    a_force_toggle_a: assert property (   // R01
        forceA && !matchA && ctrlA.outputModeA == COM_TOGGLE |=> waveOutA != $past(waveOutA))
        else $error("Forced toggle did not change output A.");
    a_force_pwm_inert: assert property (   // R02
        ctrlBWrite && pwdata[FORCE_A_BIT] && isPwm && !tick && !wrapTick |=> $stable(waveOutA))
        else $error("Force strobe acted in a PWM mode.");
    a_force_no_flag: assert property (   // R04
        forceB && !matchB && !flags[FLAG_CMP_B] |=> !flags[FLAG_CMP_B])
        else $error("Forced compare set a flag.");
    a_strobes_read_zero: assert property (   // R05
        hitCtrlB |-> readByte[7:4] == 4'h0)
        else $error("Control B strobe or reserved bits read nonzero.");
    a_flags_reserved_zero: assert property (   // R06
        (hitFlags || hitMask) |-> readByte[7:3] == 5'h00)
        else $error("Reserved mask or flag bits read nonzero.");
    a_div8_spacing: assert property (   // R07
        tick && clockSelect == CS_DIV8 |=> (!tick || clockSelect != CS_DIV8) [*7])
        else $error("Divide-by-8 tick came too soon.");
    a_ext_rise_tick: assert property (   // R08
        clockSelect == CS_EXT_RISE && $rose(extLevel) |-> tick)
        else $error("Rising count-pin edge did not tick.");
    a_count_write: assert property (   // R10
        countWrite |=> count == $past(pwdata[7:0]) && blockNext)
        else $error("Counter write not taken.");
    a_write_blocks: assert property (   // R11
        blockNext && tick |-> !matchA && !matchB)
        else $error("Compare match after counter write.");
    a_irq_gate: assert property (   // R13
        irqRequest[FLAG_CMP_A] == (irqMask[FLAG_CMP_A] && globalEnable && flags[FLAG_CMP_A]))
        else $error("Interrupt request not gated correctly.");
    a_match_sets_flag: assert property (   // R14
        matchA |=> flags[FLAG_CMP_A] ##1 (flags[FLAG_CMP_A] || $past(flagClear[FLAG_CMP_A])))
        else $error("Compare A match did not set its flag.");
    a_vector_clears: assert property (   // R15
        vectorAck[FLAG_CMP_B] && !matchB |=> !flags[FLAG_CMP_B])
        else $error("Vector execution did not clear flag.");
    a_w1c_clear: assert property (   // R16
        flagWrite && pwdata[FLAG_OVF] && !ovfEvent |=> !flags[FLAG_OVF])
        else $error("Write-one did not clear overflow flag.");
    a_ovf_normal: assert property (   // R17 R18
        tick && waveMode == WM_NORMAL && count == COUNT_MAX && !countWrite
            |=> flags[FLAG_OVF] && count == COUNT_BOTTOM)
        else $error("Normal-mode overflow not flagged at MAX.");
    a_stop_holds: assert property (   // R21
        clockSelect == CS_STOP && !countWrite && !forceA |=> $stable(count) && $stable(waveOutA))
        else $error("Stopped timer changed state.");

    c_match_irq:  cover property (matchA && irqMask[FLAG_CMP_A] && globalEnable ##1 irqRequest[1]);
    c_force_b:    cover property (forceB && ctrlA.outputModeB == COM_SET);
    c_pc_ovf:     cover property (isPc && ovfEvent);
    c_ext_tick:   cover property (clockSelect == CS_EXT_FALL && tick);

endmodule

/* File: tb.sv */
// Self-checking bench for the 8-bit timer control and interrupt block.
`timescale 1ns/1ps
module tb
    import timer8_pkg::*;
;
    // Stimulus, observed outputs and bench bookkeeping.
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        extCountPin = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [2:0]  vectorAck = 3'h0;
    logic [31:0] prdata, rd, v, seed = 32'h47;
    logic        pready, pslverr, er, waveOutA, waveEnableA, waveOutB, waveEnableB;
    logic [2:0]  irqRequest;
    int          num_errors = 0, tests_run = 0, cycles = 0, oa = 0, lo;
    logic [7:0]  adr[5] = '{8'h94, 8'h98, 8'h9C, 8'hA0, 8'hB8};
    logic [7:0]  rmsk[5] = '{8'h08, 8'hFF, 8'hFF, 8'hFF, 8'h07};
    logic [1:0]  fc[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    int          dv[5] = '{1, 8, 64, 256, 1024};

    timer8_ctrl_irq timer8_ctrl_irq_i (
        .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .extCountPin, .vectorAck, .irqRequest, .waveOutA,
        .waveEnableA, .waveOutB, .waveEnableB);

    // A 100 ns clock.
    initial forever #50 core_clk = ~core_clk;

    // Hang guard, far above the roughly 7000 cycles that the run needs.
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; data and error are taken only at the access edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Registered outputs are looked at away from the edge that moves them.
    task automatic settle();
        repeat (2) @(negedge core_clk);
    endtask

    task automatic finish_test();
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        tick(16);
        rst_n <= 1'b1;
        tick(3);
        // Stopped timer: random round trips, upper data bits ignored.
        repeat (4)
            foreach (adr[i])
            begin
                v = rnd();
                if (i == 0)
                    v[2:0] = CS_STOP;
                apb(1'b1, adr[i], v);
                apb(1'b0, adr[i], 0);
                chk(rd, v[7:0] & rmsk[i]);
            end
        apb(1'b0, 8'h40, 0);
        chk({rd[30:0], er}, 1);
        // At full rate a counter write hides the next match on both channels.
        apb(1'b1, 8'h98, 8'h80);
        apb(1'b1, 8'h9C, 5);
        apb(1'b1, 8'hA0, 5);
        apb(1'b1, 8'hB8, 7);
        apb(1'b1, 8'hFC, 1);
        apb(1'b1, 8'h54, 7);
        apb(1'b1, 8'h94, CS_DIV1);
        apb(1'b1, 8'h98, 5);
        apb(1'b0, 8'h54, 0);
        chk({rd[28:0], irqRequest}, 0);
        tick(300);
        apb(1'b1, 8'h94, CS_STOP);
        apb(1'b0, 8'h98, 0);
        v = rd;
        tick(40);
        apb(1'b0, 8'h98, 0);
        chk(rd, v);
        apb(1'b0, 8'h54, 0);
        chk(rd, 7);
        chk(irqRequest, 7);
        apb(1'b1, 8'hFC, 0);
        settle();
        chk(irqRequest, 0);
        apb(1'b1, 8'hFC, 1);
        vectorAck <= 3'h1;
        tick(1);
        vectorAck <= 3'h0;
        apb(1'b1, 8'h54, 0);
        apb(1'b0, 8'h54, 0);
        chk(rd, 6);
        apb(1'b1, 8'h54, 2);
        apb(1'b0, 8'h54, 0);
        chk(rd, 4);
        chk(irqRequest, 4);
        apb(1'b1, 8'h54, 4);
        // Forced strobes in CTC mode move outputs, not flags or counter.
        apb(1'b1, 8'h98, 8'h33);
        foreach (fc[i])
        begin
            apb(1'b1, 8'h90, {fc[i], fc[i], 4'h2});
            apb(1'b1, 8'h94, 8'hC0);
            oa = (fc[i] == COM_TOGGLE) ? 1 - oa : fc[i] - 2;
            settle();
            chk({waveEnableA, waveOutA, waveEnableB, waveOutB}, {2{1'b1, oa[0]}});
        end
        apb(1'b0, 8'h54, 0);
        chk(rd, 0);
        apb(1'b0, 8'h98, 0);
        chk(rd, 8'h33);
        apb(1'b1, 8'h90, 8'hF3);
        apb(1'b1, 8'h94, 8'hC0);
        settle();
        chk({waveOutA, waveOutB}, 0);
        apb(1'b1, 8'h90, 0);
        // Count-pin edges of the chosen polarity, four of each.
        for (int k = 6; k < 8; k++)
        begin
            apb(1'b1, 8'h98, 0);
            apb(1'b1, 8'h94, k);
            repeat (8)
            begin
                tick(10);
                extCountPin <= ~extCountPin;
            end
            tick(10);
            apb(1'b1, 8'h94, 0);
            apb(1'b0, 8'h98, 0);
            chk(rd, 4);
        end
        // A shared prescaler may give one early tick, hence the tolerance.
        // Fixed-top fast PWM counts like normal mode, so force bits stay zero here.
        apb(1'b1, 8'h90, 8'h03);
        foreach (dv[i])
        begin
            apb(1'b1, 8'h98, 0);
            apb(1'b1, 8'h94, i + 1);
            lo = (i == 0) ? 200 : 1500;
            tick(lo);
            apb(1'b1, 8'h94, 0);
            apb(1'b0, 8'h98, 0);
            // The select stays live until the stop write lands three edges on.
            lo = (lo + 3) / dv[i];
            chk(rd >= lo && rd <= lo + 1, 1);
        end
        finish_test();
    end
endmodule
